// File: dv/pin_model.sv
/*
  Pin side: two interrupt pins and two counter pins.
  Assumes one-cycle command pulses from the bench.
*/
`timescale 1ns/1ps
module pin_model
#(
  parameter int LOW_CYCLES = 3
)
(
  input  wire logic       mclk_in,
  input  wire logic [3:0] pulse_in,
  input  wire logic [3:0] hold_low_in,
  output logic      [3:0] pins_out
);
  int cnt_q [4] = '{0, 0, 0, 0};
  // Released pins return high as if pulled up; a low pulse outlasts the synchroniser
  always_ff @(posedge mclk_in)
    for (int i = 0; i < 4; i++)
      cnt_q[i] <= pulse_in[i] ? LOW_CYCLES : (cnt_q[i] > 0 ? cnt_q[i] - 1 : 0);
  always_comb
    for (int i = 0; i < 4; i++)
      pins_out[i] = !hold_low_in[i] && cnt_q[i] == 0;
endmodule : pin_model

// File: dv/testbench.sv
/*
  Self-checking bench for the dual timer/counter with a pin model.
  Assumes the package is compiled first; ce_in drops once to test freezing.
*/
`timescale 1ns/1ps
module testbench;
  logic       mclk_in = 1'h0, sys_rst_in = 1'h1, ce_in = 1'h1;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, d, x;
  logic       reg_wr_in = 1'h0, reg_rd_in = 1'h0;
  logic       ext_irq_pin_a_in, ext_irq_pin_b_in, counter_pin_a_in, counter_pin_b_in;
  logic       isr_ack_timer_a_in, isr_ack_timer_b_in, isr_ack_ext_a_in, isr_ack_ext_b_in;
  logic       timer_a_irq_out, timer_b_irq_out, ext_a_irq_out, ext_b_irq_out;
  logic [3:0] pins, pulse_q = 4'h0, hold_q = 4'h0, ack_q = 4'h0;
  logic [1:0] seen_q = 2'h0;
  wire  [1:0] tirq = {timer_b_irq_out, timer_a_irq_out};
  wire  [1:0] xirq = {ext_b_irq_out, ext_a_irq_out};
  int         seed = 32'h3e3d_b18b, n_fail = 0, checked = 0;
  logic [7:0] offs [7] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h80};
  assign {counter_pin_b_in, counter_pin_a_in, ext_irq_pin_b_in, ext_irq_pin_a_in} = pins;
  assign {isr_ack_ext_b_in, isr_ack_ext_a_in, isr_ack_timer_b_in, isr_ack_timer_a_in} = ack_q;
  dual_timer_counter #(.TICK_CYCLES(2)) dut (.*);
  pin_model #(.LOW_CYCLES(3)) pins_i (.mclk_in(mclk_in), .pulse_in(pulse_q),
    .hold_low_in(hold_q), .pins_out(pins));
  always #5 mclk_in = ~mclk_in;
  // Overflow flags are latched here because stopping the timer rewrites them
  always @(posedge mclk_in) seen_q = seen_q | tirq;
  task results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    checked++;
    if (got !== ex)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    {reg_wr_in, reg_addr_in, reg_wdata_in} <= {1'h1, a, v};
    @(posedge mclk_in);
    reg_wr_in <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    {reg_rd_in, reg_addr_in} <= {1'h1, a};
    @(posedge mclk_in);
    reg_rd_in <= 1'h0;
    @(posedge mclk_in);
    v = reg_rdata_out;
  endtask : rd
  task pulse(input int i);
    @(posedge mclk_in);
    pulse_q[i] <= 1'h1;
    @(posedge mclk_in);
    pulse_q[i] <= 1'h0;
    repeat (8) @(posedge mclk_in);
  endtask : pulse
  task ack(input int i);
    @(posedge mclk_in);
    ack_q[i] <= 1'h1;
    @(posedge mclk_in);
    ack_q[i] <= 1'h0;
    @(posedge mclk_in);
  endtask : ack
  function automatic timer_pkg::timer_step_t model(input logic b, input logic [1:0] m,
                                                   input logic [15:0] v, input int k);
    timer_pkg::timer_step_t r;
    logic                   o;
    logic                   cy;
    r = {1'h0, v};
    for (int i = 0; i < k; i++)
    begin
      o = 1'h0;
      case (m)
        2'h0:
        begin
          {cy, r.data.lo[4:0]} = r.data.lo[4:0] + 6'h01;
          {o, r.data.hi} = r.data.hi + 9'(cy);
        end
        2'h1: {o, r.data} = r.data + 17'h0_0001;
        2'h2:
        begin
          {o, r.data.lo} = r.data.lo + 9'h001;
          if (o) r.data.lo = r.data.hi;
        end
        default: if (!b) {o, r.data.lo} = r.data.lo + 9'h001;
      endcase
      r.ovf = r.ovf | o;
    end
    return r;
  endfunction : model
  task automatic tcase(input logic b, input logic [1:0] m, input int r);
    logic                   g, h, c;
    logic [15:0]            v;
    logic [7:0]             lo;
    int                     k;
    timer_pkg::timer_step_t e;
    {g, h, c} = r == 0 ? 3'h0 : 3'($random(seed));
    v = r == 0 ? 16'hFFFF : 16'($random(seed));
    k = 1 + $unsigned($random(seed)) % 40;
    e = model(b, m, v, g && h ? 0 : k);
    hold_q[b] <= h;
    wr(offs[1], b ? {g, c, m, 4'h0} : {4'h0, g, c, m});
    wr(offs[2 + b], v[7:0]);
    wr(offs[4 + b], v[15:8]);
    seen_q = 2'h0;
    wr(offs[0], b ? 8'h40 : 8'h10);
    if (c)
      repeat (k) pulse(2 + b);
    else
      repeat (2 * k - 2) @(posedge mclk_in);
    wr(offs[0], {seen_q[1], 1'h0, seen_q[0], 5'h00});
    hold_q[b] <= 1'h0;
    rd(offs[2 + b], lo);
    rd(offs[4 + b], d);
    chk("count", e.data, {d, lo});
    chk("overflow", 16'(e.ovf), 16'(seen_q[b]));
    if (seen_q[b])
    begin
      ack(b);
      chk("overflow clear", 16'h0000, 16'(tirq[b]));
    end
  endtask : tcase
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'h0;
    foreach (offs[i])
    begin
      rd(offs[i], d);
      chk("reset value", 16'h0000, 16'(d));
    end
    for (int i = 1; i < 7; i++)
    begin
      x = 8'($random(seed));
      wr(offs[i], x);
      rd(offs[i], d);
      chk("readback", 16'(i == 6 ? 8'h00 : x), 16'(d));
    end
    rd(offs[2], x);
    ce_in <= 1'h0;
    wr(offs[2], ~x);
    ce_in <= 1'h1;
    rd(offs[2], d);
    chk("frozen byte", 16'(x), 16'(d));
    for (int i = 0; i < 2; i++)
    begin
      wr(offs[0], i ? 8'h04 : 8'h01);
      pulse(i);
      chk("edge request", 16'h0001, 16'(xirq[i]));
      rd(offs[0], d);
      chk("edge flag", 16'h0001, 16'(d[2 * i + 1]));
      ack(2 + i);
      chk("edge clear", 16'h0000, 16'(xirq[i]));
      wr(offs[0], 8'h00);
      hold_q[i] <= 1'h1;
      repeat (6) @(posedge mclk_in);
      chk("level low", 16'h0001, 16'(xirq[i]));
      hold_q[i] <= 1'h0;
      repeat (6) @(posedge mclk_in);
      chk("level high", 16'h0000, 16'(xirq[i]));
    end
    for (int b = 0; b < 2; b++)
      for (int m = 0; m < 4; m++)
        for (int r = 0; r < 3; r++)
          tcase(1'(b), 2'(m), r);
    // Split mode: timer A high byte runs on timer B's run bit and flag
    wr(offs[1], 8'h33);
    wr(offs[4], 8'hFE);
    seen_q = 2'h0;
    wr(offs[0], 8'h40);
    repeat (2) @(posedge mclk_in);
    wr(offs[0], 8'h00);
    rd(offs[4], d);
    chk("split high", 16'h0000, 16'(d));
    chk("split overflow", 16'h0002, 16'(seen_q));
    // Reset again after the run bits are cleared, with the timer B flag still set
    sys_rst_in <= 1'h1;
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'h0;
    rd(offs[0], d);
    chk("reset control", 16'h0000, {6'h00, tirq, d});
    rd(offs[1], d);
    chk("reset mode", 16'h0000, 16'(d));
    results();
  end
  initial
  begin
    repeat (60000) @(posedge mclk_in);
    n_fail++;
    results();
  end
endmodule : testbench

// File: dv/timer_properties.sv
/*
  Port checker for the dual timer/counter, bound to its top module.
  Assumes the pins idle high; ce_in may drop for a few cycles.
*/
`timescale 1ns/1ps
module timer_checker
#(
  parameter int TICK_CYCLES = 2
)
(
  input logic       mclk_in,
  input logic       sys_rst_in,
  input logic       ce_in,
  input logic [7:0] reg_addr_in,
  input logic [7:0] reg_wdata_in,
  input logic       reg_wr_in,
  input logic       reg_rd_in,
  input logic [7:0] reg_rdata_out,
  input logic       ext_irq_pin_a_in,
  input logic       ext_irq_pin_b_in,
  input logic       counter_pin_a_in,
  input logic       counter_pin_b_in,
  input logic       isr_ack_timer_a_in,
  input logic       isr_ack_timer_b_in,
  input logic       isr_ack_ext_a_in,
  input logic       isr_ack_ext_b_in,
  input logic       timer_a_irq_out,
  input logic       timer_b_irq_out,
  input logic       ext_a_irq_out,
  input logic       ext_b_irq_out
);
  logic [7:0] ctl_q;
  logic [3:0] lo_a_q;
  logic [3:0] hi_a_q;
  logic [3:0] hi_b_q;
  // ----------------------------------------------------------------
  // Shadow of software bits and pin run lengths
  // ----------------------------------------------------------------
  // Run lengths saturate so they never wrap back under the limit
  always_ff @(posedge mclk_in)
    if (sys_rst_in)
    begin
      ctl_q  <= 8'h00;
      lo_a_q <= 4'h0;
      hi_a_q <= 4'h0;
      hi_b_q <= 4'h0;
    end
    else if (ce_in)
    begin
      if (reg_wr_in && reg_addr_in == timer_pkg::CTRL_OFFSET)
        ctl_q <= reg_wdata_in;
      lo_a_q <= ext_irq_pin_a_in ? 4'h0 : lo_a_q + 4'(lo_a_q < 4'h9);
      hi_a_q <= !ext_irq_pin_a_in ? 4'h0 : hi_a_q + 4'(hi_a_q < 4'h9);
      hi_b_q <= !ext_irq_pin_b_in ? 4'h0 : hi_b_q + 4'(hi_b_q < 4'h9);
    end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  rst_clear_a:
    assert property (disable iff (1'h0) sys_rst_in |=> !(timer_a_irq_out | timer_b_irq_out
      | ext_a_irq_out | ext_b_irq_out) && reg_rdata_out == 8'h00)
    else $error("outputs not cleared by reset");
  rd_idle_a:
    assert property (ce_in && !reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data outside its cycle");
  level_req_a:
    assert property (!ctl_q[0] && !$past(ctl_q[0]) && lo_a_q >= 4'h4 |-> ext_a_irq_out)
    else $error("level request missing");
  ext_ack_a_a:
    assert property (isr_ack_ext_a_in && ce_in && !reg_wr_in && hi_a_q >= 4'h4
      |-> ##[1:2] !ext_a_irq_out)
    else $error("edge request A not cleared");
  ext_ack_b_a:
    assert property (isr_ack_ext_b_in && ce_in && !reg_wr_in && hi_b_q >= 4'h4
      |-> ##[1:2] !ext_b_irq_out)
    else $error("edge request B not cleared");
  ovf_hold_a:
    assert property (timer_a_irq_out && !isr_ack_timer_a_in && !reg_wr_in |=> timer_a_irq_out)
    else $error("overflow flag A dropped");
  ovf_ack_a_a:
    assert property (isr_ack_timer_a_in && ce_in && !reg_wr_in && !ctl_q[4]
      |=> !timer_a_irq_out)
    else $error("overflow flag A not cleared");
  ovf_ack_b_a:
    assert property (isr_ack_timer_b_in && ce_in && !reg_wr_in && !ctl_q[6]
      |=> !timer_b_irq_out)
    else $error("overflow flag B not cleared");
  cover property (timer_a_irq_out && isr_ack_timer_a_in);
  cover property (timer_b_irq_out && isr_ack_timer_b_in);
  cover property (ext_b_irq_out && isr_ack_ext_b_in);
endmodule : timer_checker

bind dual_timer_counter timer_checker #(.TICK_CYCLES(TICK_CYCLES)) checker_i (.*);

// File: inc/timer_pkg.sv
/*
  Shared constants and types for the dual timer/counter block: register
  offsets, field positions, reset values, mode encodings and timing counts.
  Assumes an 8-bit register port and one system clock.
*/
package timer_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET   = 8'h88;
  localparam logic [7:0] MODE_OFFSET   = 8'h89;
  localparam logic [7:0] A_LOW_OFFSET  = 8'h8A;
  localparam logic [7:0] B_LOW_OFFSET  = 8'h8B;
  localparam logic [7:0] A_HIGH_OFFSET = 8'h8C;
  localparam logic [7:0] B_HIGH_OFFSET = 8'h8D;

  // ----------------------------------------------------------------------
  // Field positions in timer_control_reg
  // ----------------------------------------------------------------------
  localparam int CTRL_TYPE_A_BIT = 0;
  localparam int CTRL_EDGE_A_BIT = 1;
  localparam int CTRL_TYPE_B_BIT = 2;
  localparam int CTRL_EDGE_B_BIT = 3;
  localparam int CTRL_RUN_A_BIT  = 4;
  localparam int CTRL_OVF_A_BIT  = 5;
  localparam int CTRL_RUN_B_BIT  = 6;
  localparam int CTRL_OVF_B_BIT  = 7;

  // ----------------------------------------------------------------------
  // Field positions in timer_mode_reg (each nibble is a timer_cfg_t)
  // ----------------------------------------------------------------------
  localparam int MODE_A_LSB = 0;
  localparam int MODE_B_LSB = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic       PIN_IDLE   = 1'b1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int PRESCALE_WIDTH    = 5;
  localparam int TIMER_TICK_CYCLES = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PRESCALE = 2'b00,
    MODE_WIDE     = 2'b01,
    MODE_RELOAD   = 2'b10,
    MODE_SPLIT    = 2'b11
  } timer_mode_t;

  typedef struct packed {
    logic        gate;
    logic        count_sel;
    timer_mode_t mode;
  } timer_cfg_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } timer_data_t;

  typedef struct packed {
    logic        ovf;
    timer_data_t data;
  } timer_step_t;

endpackage : timer_pkg

// File: rtl/dual_timer_counter.sv
/*
  Dual timer/counter with two external interrupt pins: control and mode
  registers, timer data bytes, gating, counter inputs and four modes.
  Assumes a register port with read data one cycle after the read strobe,
  and an interrupt controller that pulses the acknowledge inputs when it
  vectors to the matching service routine.
*/
// Implementation choice: the strobed register port.
//
// Function
// - Timer B overflow sets flag, vector clears
// - Timer A overflow sets flag, vector clears
// - Timer B counts on run, gated by pin
// - Timer A counts on run, gated by pin
// - Pin B falling edge sets flag, vector clears
// - Pin A falling edge sets flag, vector clears
// - Pin B trigger: 0 level, 1 edge
// - Pin A trigger: 0 level, 1 edge
// - Timer B: clock/2 or counter pin fall
// - Timer A: clock/2 or counter pin fall
// - Timer B modes: prescaled 8-bit, 16-bit
// - Timer B modes: auto-reload, stopped
// - Timer A modes: prescaled 8-bit, 16-bit
// - All control and mode bits reset zero
// - Timer A reload mode; split mode uses B
//
`timescale 1ns/1ps
module dual_timer_counter
#(
  parameter int TICK_CYCLES = timer_pkg::TIMER_TICK_CYCLES
)
(
  input  wire logic       mclk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       ext_irq_pin_a_in,
  input  wire logic       ext_irq_pin_b_in,
  input  wire logic       counter_pin_a_in,
  input  wire logic       counter_pin_b_in,
  input  wire logic       isr_ack_timer_a_in,
  input  wire logic       isr_ack_timer_b_in,
  input  wire logic       isr_ack_ext_a_in,
  input  wire logic       isr_ack_ext_b_in,
  output logic            timer_a_irq_out,
  output logic            timer_b_irq_out,
  output logic            ext_a_irq_out,
  output logic            ext_b_irq_out
);

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam int PW = timer_pkg::PRESCALE_WIDTH;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]              ctrl_q;
  logic [7:0]              ctrl_d;
  logic [7:0]              mode_q;
  logic [7:0]              mode_d;
  timer_pkg::timer_data_t  data_a_q;
  timer_pkg::timer_data_t  data_a_d;
  timer_pkg::timer_data_t  data_b_q;
  timer_pkg::timer_data_t  data_b_d;
  logic [TICK_W-1:0]       tick_cnt_q;
  logic [7:0]              rdata_q;
  logic                    ext_a_req_q;
  logic                    ext_b_req_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers: index 0 ext A, 1 ext B, 2 counter A, 3 counter B
  // ----------------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] pin_level;
  logic [3:0] pin_fall;

  assign pin_raw = {counter_pin_b_in, counter_pin_a_in, ext_irq_pin_b_in, ext_irq_pin_a_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      pin_sync_edge u_sync
      (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .ce_in      (ce_in),
        .pin_in     (pin_raw[gi]),
        .level_out  (pin_level[gi]),
        .fall_out   (pin_fall[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  wire wr_ctrl   = reg_wr_in & (reg_addr_in == timer_pkg::CTRL_OFFSET);
  wire wr_mode   = reg_wr_in & (reg_addr_in == timer_pkg::MODE_OFFSET);
  wire wr_a_low  = reg_wr_in & (reg_addr_in == timer_pkg::A_LOW_OFFSET);
  wire wr_b_low  = reg_wr_in & (reg_addr_in == timer_pkg::B_LOW_OFFSET);
  wire wr_a_high = reg_wr_in & (reg_addr_in == timer_pkg::A_HIGH_OFFSET);
  wire wr_b_high = reg_wr_in & (reg_addr_in == timer_pkg::B_HIGH_OFFSET);

  assign mode_d = wr_mode ? reg_wdata_in : mode_q;

  // Unmapped addresses read as zero
  wire [7:0] rd_mux =
      (reg_addr_in == timer_pkg::CTRL_OFFSET)   ? ctrl_q      :
      (reg_addr_in == timer_pkg::MODE_OFFSET)   ? mode_q      :
      (reg_addr_in == timer_pkg::A_LOW_OFFSET)  ? data_a_q.lo :
      (reg_addr_in == timer_pkg::B_LOW_OFFSET)  ? data_b_q.lo :
      (reg_addr_in == timer_pkg::A_HIGH_OFFSET) ? data_a_q.hi :
      (reg_addr_in == timer_pkg::B_HIGH_OFFSET) ? data_b_q.hi : 8'h00;

  // ----------------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------------
  timer_pkg::timer_cfg_t cfg_a;
  timer_pkg::timer_cfg_t cfg_b;

  assign cfg_a = timer_pkg::timer_cfg_t'(mode_q[timer_pkg::MODE_A_LSB +: 4]);
  assign cfg_b = timer_pkg::timer_cfg_t'(mode_q[timer_pkg::MODE_B_LSB +: 4]);

  wire run_a  = ctrl_q[timer_pkg::CTRL_RUN_A_BIT];
  wire run_b  = ctrl_q[timer_pkg::CTRL_RUN_B_BIT];
  wire type_a = ctrl_q[timer_pkg::CTRL_TYPE_A_BIT];
  wire type_b = ctrl_q[timer_pkg::CTRL_TYPE_B_BIT];

  // ----------------------------------------------------------------------
  // Count sources
  // ----------------------------------------------------------------------
  // One shared divider keeps both timers in step on the same clock phase
  wire tick = (tick_cnt_q == TICK_LAST);

  wire enable_a = run_a & (~cfg_a.gate | pin_level[0]);
  wire enable_b = run_b & (~cfg_b.gate | pin_level[1]);

  // Pins are sampled once a clock, so pulses shorter than a clock can be lost
  wire event_a = cfg_a.count_sel ? pin_fall[2] : tick;
  wire event_b = cfg_b.count_sel ? pin_fall[3] : tick;

  wire split_a = (cfg_a.mode == timer_pkg::MODE_SPLIT);
  wire inc_a   = enable_a & event_a;
  wire inc_b   = enable_b & event_b & (cfg_b.mode != timer_pkg::MODE_SPLIT);
  // In split mode the high byte of timer A borrows timer B's run bit
  wire inc_ah  = split_a & run_b & tick;

  // ----------------------------------------------------------------------
  // Counter step
  // ----------------------------------------------------------------------
  function automatic timer_pkg::timer_step_t step_fn
  (
    input timer_pkg::timer_mode_t mode,
    input timer_pkg::timer_data_t cur,
    input logic                   inc
  );
    timer_pkg::timer_step_t r;
    r.ovf  = 1'b0;
    r.data = cur;
    if (inc)
    begin
      case (mode)
        timer_pkg::MODE_PRESCALE:
        begin
          // In the low byte only the prescaler bits move and the rest holds; the high byte steps when they wrap
          r.data.lo[PW-1:0] = cur.lo[PW-1:0] + PW'(1);
          if (&cur.lo[PW-1:0])
          begin
            r.data.hi = cur.hi + 8'h01;
            r.ovf     = &cur.hi;
          end
        end
        timer_pkg::MODE_WIDE:
        begin
          r.data = cur + 16'h0001;
          r.ovf  = &cur;
        end
        timer_pkg::MODE_RELOAD:
        begin
          if (&cur.lo)
          begin
            r.data.lo = cur.hi;
            r.ovf     = 1'b1;
          end
          else
          begin
            r.data.lo = cur.lo + 8'h01;
          end
        end
        timer_pkg::MODE_SPLIT:
        begin
          r.data.lo = cur.lo + 8'h01;
          r.ovf     = &cur.lo;
        end
        default:
        begin
          r.data = cur;
        end
      endcase
    end
    return r;
  endfunction : step_fn

  timer_pkg::timer_step_t step_a;
  timer_pkg::timer_step_t step_b;

  assign step_a = step_fn(cfg_a.mode, data_a_q, inc_a);
  assign step_b = step_fn(cfg_b.mode, data_b_q, inc_b);

  // The split high byte counts system ticks only, never counter pin edges
  wire [7:0] split_hi_next = data_a_q.hi + 8'h01;
  wire       split_hi_ovf  = inc_ah & (&data_a_q.hi);

  wire ovf_a_event = step_a.ovf;
  wire ovf_b_event = step_b.ovf | split_hi_ovf;

  // ----------------------------------------------------------------------
  // Next data bytes: a software write takes the byte in that cycle
  // ----------------------------------------------------------------------
  // Counts are not latched: software reads the two bytes one at a time
  wire [7:0] a_hi_count = split_a ? (inc_ah ? split_hi_next : data_a_q.hi) : step_a.data.hi;

  assign data_a_d.lo = wr_a_low  ? reg_wdata_in : step_a.data.lo;
  assign data_a_d.hi = wr_a_high ? reg_wdata_in : a_hi_count;
  assign data_b_d.lo = wr_b_low  ? reg_wdata_in : step_b.data.lo;
  assign data_b_d.hi = wr_b_high ? reg_wdata_in : step_b.data.hi;

  // ----------------------------------------------------------------------
  // Next control register: hardware set wins over any clear
  // ----------------------------------------------------------------------
  wire [7:0] ctrl_base = wr_ctrl ? reg_wdata_in : ctrl_q;

  wire [7:0] clr_mask =
      ({7'h00, isr_ack_ext_a_in}   << timer_pkg::CTRL_EDGE_A_BIT) |
      ({7'h00, isr_ack_ext_b_in}   << timer_pkg::CTRL_EDGE_B_BIT) |
      ({7'h00, isr_ack_timer_a_in} << timer_pkg::CTRL_OVF_A_BIT)  |
      ({7'h00, isr_ack_timer_b_in} << timer_pkg::CTRL_OVF_B_BIT);

  wire [7:0] set_mask =
      ({7'h00, pin_fall[0]} << timer_pkg::CTRL_EDGE_A_BIT) |
      ({7'h00, pin_fall[1]} << timer_pkg::CTRL_EDGE_B_BIT) |
      ({7'h00, ovf_a_event} << timer_pkg::CTRL_OVF_A_BIT)  |
      ({7'h00, ovf_b_event} << timer_pkg::CTRL_OVF_B_BIT);

  assign ctrl_d = (ctrl_base & ~clr_mask) | set_mask;

  // Requests are raw: interrupt enables and priorities live outside this block
  // Level mode requests follow the pin; edge mode requests follow the flag
  wire ext_a_req_d = type_a ? ctrl_d[timer_pkg::CTRL_EDGE_A_BIT] : ~pin_level[0];
  wire ext_b_req_d = type_b ? ctrl_d[timer_pkg::CTRL_EDGE_B_BIT] : ~pin_level[1];

  // Read data fall back to zero outside the cycle after a strobe
  wire [7:0]        rdata_d    = reg_rd_in ? rd_mux : 8'h00;
  wire [TICK_W-1:0] tick_cnt_d = tick ? '0 : tick_cnt_q + TICK_W'(1);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_q <= timer_pkg::CTRL_RESET;
      mode_q <= timer_pkg::MODE_RESET;
    end
    else if (ce_in)
    begin
      ctrl_q <= ctrl_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      data_a_q <= {timer_pkg::DATA_RESET, timer_pkg::DATA_RESET};
      data_b_q <= {timer_pkg::DATA_RESET, timer_pkg::DATA_RESET};
    end
    else if (ce_in)
    begin
      data_a_q <= data_a_d;
      data_b_q <= data_b_d;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      tick_cnt_q <= '0;
    end
    else if (ce_in)
    begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_q <= 8'h00;
    end
    else if (ce_in)
    begin
      rdata_q <= rdata_d;
    end
  end

  // Idle pins are high, so level requests start inactive
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      ext_a_req_q <= 1'b0;
      ext_b_req_q <= 1'b0;
    end
    else if (ce_in)
    begin
      ext_a_req_q <= ext_a_req_d;
      ext_b_req_q <= ext_b_req_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata_out   = rdata_q;
  assign timer_a_irq_out = ctrl_q[timer_pkg::CTRL_OVF_A_BIT];
  assign timer_b_irq_out = ctrl_q[timer_pkg::CTRL_OVF_B_BIT];
  assign ext_a_irq_out   = ext_a_req_q;
  assign ext_b_irq_out   = ext_b_req_q;

endmodule : dual_timer_counter

// File: rtl/pin_sync_edge.sv
/*
  Two-stage synchroniser with a falling-edge detector for one input pin.
  Assumes the pin idles high and that ce_in freezes the stages.
*/
`timescale 1ns/1ps
module pin_sync_edge
(
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic ce_in,
  input  wire logic pin_in,
  output logic      level_out,
  output logic      fall_out
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  // Reset to idle high so the release of reset never looks like an edge
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      meta_q <= timer_pkg::PIN_IDLE;
      sync_q <= timer_pkg::PIN_IDLE;
      last_q <= timer_pkg::PIN_IDLE;
    end
    else if (ce_in)
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign fall_out  = last_q & ~sync_q;

endmodule : pin_sync_edge
